// >>> pcg_pkg.sv
/*
 * Constants, types and register map of the peripheral clock gating block.
 * Assumes one system clock and a synchronous active-low chip reset.
 */
// How it works
// - Set enable bit clocks its unit
// - Access to unclocked unit gives bus fault
// - Enables reset cleared except hibernation bit 6, set in run, sleep and deep
// - Run, sleep, deep-sleep registers chosen by state
// - Sleep registers apply only with auto gating
// - Run register at 0x100, reset 0x40
// - Sleep register at offset 0x110
// - Run register bits 11:8 pick converter sample rate; sleep and deep bits 11:8 are only stored
// - Bit 6 gates hibernation clock
// - Bit 3 gates watchdog, faults when off
// - Reserved bits read zero, ignore writes
package pcg_pkg;

	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int NUM_UNITS = 2;
	localparam int RATE_W = 4;

	localparam logic [ADDR_W-1:0] OFF_RUN = 12'h100;
	localparam logic [ADDR_W-1:0] OFF_SLEEP = 12'h110;
	localparam logic [ADDR_W-1:0] OFF_DEEP = 12'h120;
	localparam logic [ADDR_W-1:0] OFF_CFG = 12'h130;
	localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 12'h140;
	localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 12'h144;

	localparam logic [DATA_W-1:0] RESET_RUN = 32'h00000040;
	localparam logic [DATA_W-1:0] RESET_SLEEP = 32'h00000040;
	localparam logic [DATA_W-1:0] RESET_DEEP = 32'h00000040;
	localparam logic [DATA_W-1:0] GATE_WRITE_MASK = 32'h00000F48;
	localparam logic [DATA_W-1:0] ZERO_WORD = 32'h00000000;

	localparam int HIBERNATION_BIT = 6;
	localparam int WATCHDOG_BIT = 3;
	localparam int RATE_LSB = 8;
	localparam int CFG_AUTO_BIT = 0;

	localparam int UNIT_HIBERNATION = 0;
	localparam int UNIT_WATCHDOG = 1;

	localparam logic [RATE_W-1:0] RATE_125K = 4'h0;
	localparam logic [RATE_W-1:0] RATE_250K = 4'h1;
	localparam logic [RATE_W-1:0] RATE_500K = 4'h2;

	typedef enum logic [1:0] {
		PCG_PWR_RUN = 2'b00,
		PCG_PWR_SLEEP = 2'b01,
		PCG_PWR_DEEP = 2'b10
	} pcg_power_e;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} pcg_bus_req_s;

	typedef struct packed {
		logic [DATA_W-1:0] run_q;
		logic [DATA_W-1:0] sleep_q;
		logic [DATA_W-1:0] deep_q;
		logic auto_q;
		logic [NUM_UNITS-1:0] irq_stat_q;
		logic [NUM_UNITS-1:0] irq_mask_q;
		logic [DATA_W-1:0] rdata_q;
		logic [NUM_UNITS-1:0] en_q;
		logic [NUM_UNITS-1:0] fault_q;
		logic [RATE_W-1:0] rate_q;
	} pcg_state_s;

endpackage : pcg_pkg

// >>> pcg_clk_gate.sv
/*
 * Glitch-free clock gate for one unit.
 * Assumes the enable changes only just after a rising clock edge.
 */
`timescale 1ns/10ps
module pcg_clk_gate (
	input wire logic clk_i,
	input wire logic en_i,
	output logic clk_o
);

	logic en_lat;

	// Transparent while clock low, so the gate never cuts a high phase
	always_latch begin
		if (!clk_i) begin
			en_lat = en_i;
		end
	end

	assign clk_o = clk_i & en_lat;

endmodule : pcg_clk_gate

// >>> pcg_gating.sv
/*
 * Peripheral clock gating control: run, sleep and deep-sleep enable
 * registers, power-state selection, gated unit clocks, bus fault on
 * access to an unclocked unit, sample-rate limit field and interrupt.
 * Assumes power_state_i and unit_access_i come from logic on core_clk_i,
 * and that the register master keeps the strobe protocol of the bus.
 */
`timescale 1ns/10ps
module pcg_gating #(
	parameter logic [pcg_pkg::RATE_W-1:0] MAX_RATE = pcg_pkg::RATE_500K
) (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire pcg_pkg::pcg_bus_req_s bus_req_i,
	output logic [pcg_pkg::DATA_W-1:0] bus_rdata_o,
	input wire logic [1:0] power_state_i,
	input wire logic [pcg_pkg::NUM_UNITS-1:0] unit_access_i,
	output logic [pcg_pkg::NUM_UNITS-1:0] bus_fault_o,
	output logic [pcg_pkg::NUM_UNITS-1:0] unit_clk_en_o,
	output logic [pcg_pkg::NUM_UNITS-1:0] unit_clk_o,
	output logic [pcg_pkg::RATE_W-1:0] sample_rate_limit_o,
	output logic irq_o
);

	pcg_pkg::pcg_state_s st_q;
	pcg_pkg::pcg_state_s st_d;

	logic [pcg_pkg::DATA_W-1:0] gate_sel;
	logic [pcg_pkg::NUM_UNITS-1:0] gate_bits;
	logic [pcg_pkg::DATA_W-1:0] wr_gate_word;
	logic [pcg_pkg::RATE_W-1:0] wr_rate;
	logic [pcg_pkg::NUM_UNITS-1:0] fault_evt;
	logic wr_run;
	logic wr_sleep;
	logic wr_deep;
	logic wr_cfg;
	logic wr_stat;
	logic wr_mask;

	// Address decode of the write strobe
	always_comb begin
		wr_run = 1'b0;
		wr_sleep = 1'b0;
		wr_deep = 1'b0;
		wr_cfg = 1'b0;
		wr_stat = 1'b0;
		wr_mask = 1'b0;
		if (bus_req_i.wr) begin
			case (bus_req_i.addr)
				pcg_pkg::OFF_RUN: begin
					wr_run = 1'b1;
				end
				pcg_pkg::OFF_SLEEP: begin
					wr_sleep = 1'b1;
				end
				pcg_pkg::OFF_DEEP: begin
					wr_deep = 1'b1;
				end
				pcg_pkg::OFF_CFG: begin
					wr_cfg = 1'b1;
				end
				pcg_pkg::OFF_IRQ_STAT: begin
					wr_stat = 1'b1;
				end
				pcg_pkg::OFF_IRQ_MASK: begin
					wr_mask = 1'b1;
				end
				default: begin
					wr_run = 1'b0;
				end
			endcase
		end
	end

	// Rate field of a write, held to the permitted maximum
	always_comb begin
		wr_rate = bus_req_i.wdata[pcg_pkg::RATE_LSB +: pcg_pkg::RATE_W];
		if (wr_rate > MAX_RATE) begin
			wr_rate = MAX_RATE;
		end
	end

	// Clamping beats storing an illegal code the converter cannot run at
	always_comb begin
		wr_gate_word = bus_req_i.wdata;
		wr_gate_word[pcg_pkg::RATE_LSB +: pcg_pkg::RATE_W] = wr_rate;
		wr_gate_word = wr_gate_word & pcg_pkg::GATE_WRITE_MASK;
	end

	// Register in force for the present power state
	always_comb begin
		gate_sel = st_q.run_q;
		if (st_q.auto_q) begin
			case (power_state_i)
				pcg_pkg::PCG_PWR_RUN: begin
					gate_sel = st_q.run_q;
				end
				pcg_pkg::PCG_PWR_SLEEP: begin
					gate_sel = st_q.sleep_q;
				end
				pcg_pkg::PCG_PWR_DEEP: begin
					gate_sel = st_q.deep_q;
				end
				default: begin
					gate_sel = st_q.run_q;
				end
			endcase
		end
	end

	// Unit enables picked out of the selected word
	always_comb begin
		gate_bits = '0;
		gate_bits[pcg_pkg::UNIT_HIBERNATION] = gate_sel[pcg_pkg::HIBERNATION_BIT];
		gate_bits[pcg_pkg::UNIT_WATCHDOG] = gate_sel[pcg_pkg::WATCHDOG_BIT];
	end

	assign fault_evt = unit_access_i & ~st_q.en_q;

	// Next state of every register
	always_comb begin
		st_d = st_q;

		if (wr_run) begin
			st_d.run_q = wr_gate_word;
		end
		if (wr_sleep) begin
			st_d.sleep_q = wr_gate_word;
		end
		if (wr_deep) begin
			st_d.deep_q = wr_gate_word;
		end
		if (wr_cfg) begin
			st_d.auto_q = bus_req_i.wdata[pcg_pkg::CFG_AUTO_BIT];
		end
		if (wr_mask) begin
			st_d.irq_mask_q = bus_req_i.wdata[pcg_pkg::NUM_UNITS-1:0];
		end

		// Write-one-to-clear; a fault in the same cycle wins over the clear
		if (wr_stat) begin
			st_d.irq_stat_q = st_q.irq_stat_q & ~bus_req_i.wdata[pcg_pkg::NUM_UNITS-1:0];
		end
		st_d.irq_stat_q = st_d.irq_stat_q | fault_evt;

		st_d.en_q = gate_bits;
		st_d.fault_q = fault_evt;

		st_d.rate_q = st_q.run_q[pcg_pkg::RATE_LSB +: pcg_pkg::RATE_W];

		// Read data stand only in the cycle after the strobe
		st_d.rdata_q = pcg_pkg::ZERO_WORD;
		if (bus_req_i.rd) begin
			case (bus_req_i.addr)
				pcg_pkg::OFF_RUN: begin
					st_d.rdata_q = st_q.run_q;
				end
				pcg_pkg::OFF_SLEEP: begin
					st_d.rdata_q = st_q.sleep_q;
				end
				pcg_pkg::OFF_DEEP: begin
					st_d.rdata_q = st_q.deep_q;
				end
				pcg_pkg::OFF_CFG: begin
					st_d.rdata_q[pcg_pkg::CFG_AUTO_BIT] = st_q.auto_q;
				end
				pcg_pkg::OFF_IRQ_STAT: begin
					st_d.rdata_q[pcg_pkg::NUM_UNITS-1:0] = st_q.irq_stat_q;
				end
				pcg_pkg::OFF_IRQ_MASK: begin
					st_d.rdata_q[pcg_pkg::NUM_UNITS-1:0] = st_q.irq_mask_q;
				end
				default: begin
					st_d.rdata_q = pcg_pkg::ZERO_WORD;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			st_q.run_q <= pcg_pkg::RESET_RUN;
			st_q.sleep_q <= pcg_pkg::RESET_SLEEP;
			st_q.deep_q <= pcg_pkg::RESET_DEEP;
			st_q.auto_q <= 1'b0;
			st_q.irq_stat_q <= '0;
			st_q.irq_mask_q <= '0;
			st_q.rdata_q <= pcg_pkg::ZERO_WORD;
			st_q.en_q <= '0;
			st_q.fault_q <= '0;
			st_q.rate_q <= pcg_pkg::RATE_125K;
		end else begin
			st_q <= st_d;
		end
	end

	// One gate cell per unit; enable changes after rising edges only
	genvar gi;
	generate
		for (gi = 0; gi < pcg_pkg::NUM_UNITS; gi++) begin : g_gate
			pcg_clk_gate u_gate (
				.clk_i(core_clk_i),
				.en_i(st_q.en_q[gi]),
				.clk_o(unit_clk_o[gi])
			);
		end
	endgenerate

	assign bus_rdata_o = st_q.rdata_q;
	assign bus_fault_o = st_q.fault_q;
	assign unit_clk_en_o = st_q.en_q;
	assign sample_rate_limit_o = st_q.rate_q;
	assign irq_o = |(st_q.irq_stat_q & st_q.irq_mask_q);

endmodule : pcg_gating

// >>> pcg_gating_sva.sv
/* Port assertions for pcg_gating.
   Assumes one clock and a synchronous active-low reset. */
`timescale 1ns/10ps
module pcg_gating_sva #(
	parameter logic [pcg_pkg::RATE_W-1:0] MAX_RATE = 4'h2
) (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire pcg_pkg::pcg_bus_req_s bus_req_i,
	input wire logic [31:0] bus_rdata_o,
	input wire logic [1:0] power_state_i,
	input wire logic [1:0] unit_access_i,
	input wire logic [1:0] bus_fault_o,
	input wire logic [1:0] unit_clk_en_o,
	input wire logic [1:0] unit_clk_o,
	input wire logic [3:0] sample_rate_limit_o,
	input wire logic irq_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);
	chk_fault_cause: assert property ($past(rst_n_i) |->
		bus_fault_o == ($past(unit_access_i) & ~$past(unit_clk_en_o))) else $error("bad fault");
	chk_rd_idle: assert property (!$past(bus_req_i.rd) |-> bus_rdata_o == 32'h0)
		else $error("read data outside read");
	chk_resv_zero: assert property ($past(bus_req_i.rd) &&
		$past(bus_req_i.addr) inside {12'h100, 12'h110, 12'h120}
		|-> (bus_rdata_o & ~32'h00000F48) == 32'h0) else $error("reserved bits set");
	chk_rate_max: assert property (sample_rate_limit_o <= MAX_RATE)
		else $error("rate above limit");
	chk_rate_follow: assert property ($past(bus_req_i.wr) &&
		$past(bus_req_i.addr) == 12'h100 && $past(bus_req_i.wdata[11:8]) <= MAX_RATE
		|=> sample_rate_limit_o == $past(bus_req_i.wdata[11:8], 2)) else $error("rate lost");
	chk_en_hold: assert property (($past(rst_n_i) && !bus_req_i.wr &&
		$stable(power_state_i)) [*3] |-> $stable(unit_clk_en_o)) else $error("enable moved");
	chk_irq_hold: assert property (irq_o && !bus_req_i.wr |=> irq_o)
		else $error("interrupt dropped");
	// Latch gate: enable seen one cycle late
	chk_gate_clk: assert property (@(negedge core_clk_i)
		unit_clk_o == $past(unit_clk_en_o)) else $error("gated clock wrong");
	cover property (bus_fault_o[1]);
	cover property (irq_o);
	cover property (power_state_i == 2'h2);
endmodule : pcg_gating_sva

bind pcg_gating pcg_gating_sva #(.MAX_RATE(MAX_RATE)) u_sva (.core_clk_i(core_clk_i),
	.rst_n_i(rst_n_i), .bus_req_i(bus_req_i), .bus_rdata_o(bus_rdata_o),
	.power_state_i(power_state_i), .unit_access_i(unit_access_i), .bus_fault_o(bus_fault_o),
	.unit_clk_en_o(unit_clk_en_o), .unit_clk_o(unit_clk_o),
	.sample_rate_limit_o(sample_rate_limit_o), .irq_o(irq_o));

// >>> pcg_periph_model.sv
/* Gated peripheral model: one-cycle access pulses, returns fault seen.
   Assumes faults come one cycle after the access. */
`timescale 1ns/10ps
module pcg_periph_model (
	input wire logic clk_i,
	output logic [1:0] access_o,
	input wire logic [1:0] fault_i
);
	initial access_o = 2'h0;
	task automatic touch(input int u, output logic [1:0] f);
		@(posedge clk_i) access_o <= 2'h1 << u;
		@(posedge clk_i) access_o <= 2'h0;
		#1 f = fault_i;
	endtask : touch
endmodule : pcg_periph_model

// >>> tb_top.sv
/* Self-checking bench for pcg_gating.
   Assumes the checker binds itself and the peripheral model drives accesses. */
`timescale 1ns/10ps
module tb_top;
	logic core_clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	pcg_pkg::pcg_bus_req_s req = '0;
	logic [1:0] ps = 2'h0;
	logic [31:0] rdata;
	logic [1:0] acc, flt, en, gclk, f;
	logic [3:0] rate, e;
	logic irq;
	int n_mismatch, tests_run;
	logic [11:0] offs[3] = '{12'h100, 12'h110, 12'h120};
	pcg_gating #(.MAX_RATE(4'h2)) DUT (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
		.bus_req_i(req), .bus_rdata_o(rdata), .power_state_i(ps), .unit_access_i(acc),
		.bus_fault_o(flt), .unit_clk_en_o(en), .unit_clk_o(gclk),
		.sample_rate_limit_o(rate), .irq_o(irq));
	pcg_periph_model PM (.clk_i(core_clk_i), .access_o(acc), .fault_i(flt));
	initial forever #2 core_clk_i = ~core_clk_i;
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge core_clk_i) req <= {a, d, 1'b1, 1'b0};
		@(posedge core_clk_i) req <= '0;
	endtask : wr
	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		@(posedge core_clk_i) req <= {a, 32'h0, 1'b0, 1'b1};
		@(posedge core_clk_i) req <= '0;
		#1 chk(rdata, exp);
	endtask : rd
	task automatic setps(input logic [1:0] v, input logic [1:0] exp);
		@(posedge core_clk_i) ps <= v;
		@(posedge core_clk_i);
		#1 chk(en, exp);
	endtask : setps
	task automatic t_reset;
		foreach (offs[i]) rd(offs[i], 32'h00000040);
		chk(en, 2'h1);
		chk(rate, 4'h0);
		chk(irq, 1'b0);
		$display("t_reset done");
	endtask : t_reset
	task automatic t_rate;
		for (int r = 0; r < 4; r++) begin
			wr(12'h100, {20'h0, 4'(r), 8'h48});
			e = (r > 2) ? 4'h2 : 4'(r);
			rd(12'h100, {20'h0, e, 8'h48});
			chk(rate, e);
		end
		wr(12'h100, 32'hFFFFF0FF);
		rd(12'h100, 32'h00000048);
		rd(12'h104, 32'h0);
		$display("t_rate done");
	endtask : t_rate
	task automatic t_fault;
		wr(12'h100, 32'h00000040);
		wr(12'h144, 32'h2);
		PM.touch(1, f);
		chk(f, 2'h2);
		chk(irq, 1'b1);
		PM.touch(0, f);
		chk(f, 2'h0);
		rd(12'h140, 32'h2);
		wr(12'h140, 32'h2);
		#1 chk(irq, 1'b0);
		wr(12'h100, 32'h00000048);
		PM.touch(1, f);
		chk(f, 2'h0);
		$display("t_fault done");
	endtask : t_fault
	task automatic t_power;
		wr(12'h110, 32'h8);
		wr(12'h120, 32'h0);
		setps(2'h1, 2'h3);
		wr(12'h130, 32'h1);
		@(posedge core_clk_i);
		#1 chk(en, 2'h2);
		setps(2'h2, 2'h0);
		setps(2'h3, 2'h3);
		$display("t_power done");
	endtask : t_power
	task automatic close_out;
		$display("compares %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : close_out
	// Whole run is under a hundred cycles
	initial begin
		#20000;
		n_mismatch++;
		close_out();
	end
	initial begin
		repeat (8) @(posedge core_clk_i);
		rst_n_i <= 1'b1;
		@(posedge core_clk_i);
		t_reset();
		t_rate();
		t_fault();
		t_power();
		close_out();
	end
endmodule : tb_top
